/* acs_far_model.sv */
module acs_far_model
	import acs_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [11:0] trial,
	input wire logic [3:0] mux_sel,
	input wire logic id_req,
	output logic comp_hi,
	output logic id_valid,
	output logic [3:0] channel_id
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// analog side: each input holds a level unique to its channel
	logic [3:0] ids [0:5];
	int idx;
	assign comp_hi = (trial <= {mux_sel, 8'hA5});
	// ============================================================
	// channel list in external memory, stop code last
	initial
	begin
		ids[0] = 4'h2;
		ids[1] = 4'h8;
		ids[2] = 4'h5;
		ids[3] = 4'h3;
		ids[4] = 4'h3;
		ids[5] = 4'hF;
	end
	// id line is not held after valid drops: show the inverse
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			id_valid <= 1'b0;
			channel_id <= 4'h0;
			idx <= 0;
		end
		else if (id_valid)
		begin
			id_valid <= 1'b0;
			channel_id <= ~channel_id;
			idx <= (idx < 5) ? idx + 1 : 5;
		end
		else if (id_req)
		begin
			id_valid <= 1'b1;
			channel_id <= ids[idx];
		end
	end
endmodule

/* acs_pkg.sv */
package acs_pkg;
	// ============================================================
	// register map
	localparam logic [7:0] ACS_STATUS_ADDR = 8'hF5;
	localparam logic [7:0] ACS_CONTROL_TWO_ADDR = 8'hD8;
	localparam logic [7:0] ACS_CONTROL_ONE_ADDR = 8'hEF;
	localparam logic [7:0] ACS_STATUS_RESET = 8'h00;
	localparam logic [7:0] ACS_CONTROL_RESET = 8'h00;
	localparam int ACS_BUSY_BIT = 7;
	// control_two fields
	localparam int ACS_DMA_BIT = 6;
	localparam int ACS_CCONV_BIT = 5;
	localparam int ACS_SCONV_BIT = 4;
	localparam int ACS_CS_LSB = 0;
	// control_one fields: acquisition and clock divide
	localparam int ACS_ACQ_LSB = 2;
	localparam int ACS_DIV_LSB = 4;
	// ============================================================
	// channel codes
	localparam logic [3:0] ACS_CODE_LAST_EXT = 4'h7;
	localparam logic [3:0] ACS_CODE_TEMP = 4'h8;
	localparam logic [3:0] ACS_CODE_STOP = 4'hF;
	localparam logic [3:0] ACS_CH_TEMP = 4'h8;
	// ============================================================
	// timing, in adc clocks
	localparam logic [3:0] ACS_SAR_BITS = 4'hC;
	localparam logic [3:0] ACS_SYNC_CLKS = 4'h1;
	localparam logic [5:0] ACS_CAL_CLKS = 6'h20;
	typedef enum logic [2:0] {ACS_IDLE, ACS_SYNC, ACS_SAMPLE, ACS_HOLD, ACS_CAL} acs_state_t;
endpackage

/* acs_sar_step.sv */
module acs_sar_step
	import acs_pkg::*;
(
	input wire logic [3:0] bit_idx,
	input wire logic [11:0] sar_in,
	input wire logic comp_hi,
	output logic [11:0] sar_out
);
	// ============================================================
	// one binary-search step: keep or drop current trial bit, try next
	always_comb
	begin
		sar_out = sar_in;
		if (!comp_hi)
		begin
			sar_out[bit_idx] = 1'b0;
		end
		if (bit_idx != 4'h0)
		begin
			sar_out[bit_idx - 4'h1] = 1'b1;
		end
	end
endmodule

/* acs_top.sv */
module acs_top
	import acs_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	output logic [7:0] SFR_RDATA,
	input wire logic CAL_START,
	input wire logic DMA_ID_VALID,
	input wire logic [3:0] DMA_CHANNEL_ID,
	output logic DMA_ID_REQ,
	input wire logic COMP_HI,
	output logic [3:0] MUX_SEL,
	output logic TRACK,
	output logic [11:0] SAR_TRIAL,
	output logic [11:0] RESULT,
	output logic RESULT_VALID,
	output logic DMA_DONE
);
	// ============================================================
	// registers
	logic [7:0] control_two_q;
	logic [7:0] control_one_q;
	acs_state_t state_q;
	logic [1:0] div_cnt_q;
	logic [5:0] phase_cnt_q;
	logic [3:0] bit_q;
	logic [11:0] sar_q;
	logic [11:0] sar_d;
	logic [3:0] chan_q;
	logic busy_q;
	logic dma_wait_q;
	logic adc_tick;
	logic [1:0] div_sel;
	logic [1:0] acq_sel;
	logic start_req;
	logic dma_mode;
	logic code_valid;

	assign div_sel = control_one_q[ACS_DIV_LSB +: 2];
	assign acq_sel = control_one_q[ACS_ACQ_LSB +: 2];
	assign dma_mode = control_two_q[ACS_DMA_BIT];
	assign start_req = control_two_q[ACS_SCONV_BIT] | control_two_q[ACS_CCONV_BIT];
	// reserved codes in control_two never start a conversion; dma channel ids are not checked
	assign code_valid = (control_two_q[3:0] <= ACS_CODE_LAST_EXT)
		|| (control_two_q[3:0] == ACS_CODE_TEMP);

	// ============================================================
	// adc clock divider, ratio 1/2/3/4 picked by software
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			div_cnt_q <= 2'h0;
		else if (adc_tick)
			div_cnt_q <= 2'h0;
		else
			div_cnt_q <= div_cnt_q + 2'h1;
	end
	assign adc_tick = (div_cnt_q == div_sel);

	// ============================================================
	// control registers; sconv self-clears at end of single conversion
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			control_two_q <= ACS_CONTROL_RESET;
			control_one_q <= ACS_CONTROL_RESET;
		end
		else
		begin
			if (SFR_WR && SFR_ADDR == ACS_CONTROL_TWO_ADDR)
				control_two_q <= SFR_WDATA;
			else if (state_q == ACS_HOLD && adc_tick && bit_q == 4'h0)
				control_two_q[ACS_SCONV_BIT] <= 1'b0;
			else if (dma_mode && DMA_ID_VALID && DMA_CHANNEL_ID == ACS_CODE_STOP)
				control_two_q[ACS_CCONV_BIT] <= 1'b0;
			if (SFR_WR && SFR_ADDR == ACS_CONTROL_ONE_ADDR)
				control_one_q <= SFR_WDATA;
		end
	end

	// ============================================================
	// conversion sequencer: sync, sample (track), hold (search)
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state_q <= ACS_IDLE;
			phase_cnt_q <= 6'h00;
			bit_q <= 4'h0;
			sar_q <= 12'h000;
			SAR_TRIAL <= 12'h000;
			chan_q <= 4'h0;
			dma_wait_q <= 1'b0;
			DMA_DONE <= 1'b0;
		end
		else
		begin
			DMA_DONE <= 1'b0;
			case (state_q)
				ACS_IDLE:
				begin
					if (CAL_START)
					begin
						state_q <= ACS_CAL;
						phase_cnt_q <= ACS_CAL_CLKS;
					end
					else if (start_req && dma_mode)
					begin
						dma_wait_q <= 1'b1;
						if (dma_wait_q && DMA_ID_VALID)
						begin
							dma_wait_q <= 1'b0;
							if (DMA_CHANNEL_ID == ACS_CODE_STOP)
								DMA_DONE <= 1'b1;
							else
							begin
								chan_q <= DMA_CHANNEL_ID;
								state_q <= ACS_SYNC;
								phase_cnt_q <= {2'h0, ACS_SYNC_CLKS};
							end
						end
					end
					else if (start_req && code_valid)
					begin
						chan_q <= control_two_q[3:0];
						state_q <= ACS_SYNC;
						phase_cnt_q <= {2'h0, ACS_SYNC_CLKS};
					end
				end
				ACS_SYNC:
				begin
					if (adc_tick)
					begin
						state_q <= ACS_SAMPLE;
						phase_cnt_q <= {4'h0, acq_sel} + 6'h01;
					end
				end
				ACS_SAMPLE:
				begin
					if (adc_tick)
					begin
						if (phase_cnt_q == 6'h01)
						begin
							state_q <= ACS_HOLD;
							bit_q <= ACS_SAR_BITS - 4'h1;
							sar_q <= 12'h800;
							// trial flop moves with sar_q: comparator must see the live trial
							SAR_TRIAL <= 12'h800;
						end
						else
							phase_cnt_q <= phase_cnt_q - 6'h01;
					end
				end
				ACS_HOLD:
				begin
					if (adc_tick)
					begin
						sar_q <= sar_d;
						SAR_TRIAL <= sar_d;
						if (bit_q == 4'h0)
							state_q <= ACS_IDLE;
						else
							bit_q <= bit_q - 4'h1;
					end
				end
				ACS_CAL:
				begin
					if (adc_tick)
					begin
						if (phase_cnt_q == 6'h01)
							state_q <= ACS_IDLE;
						else
							phase_cnt_q <= phase_cnt_q - 6'h01;
					end
				end
				default:
					state_q <= ACS_IDLE;
			endcase
		end
	end

	acs_sar_step u_step
	(
		.bit_idx(bit_q),
		.sar_in(sar_q),
		.comp_hi(COMP_HI),
		.sar_out(sar_d)
	);

	// ============================================================
	// result latch and analog front-end drive
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			RESULT <= 12'h000;
			RESULT_VALID <= 1'b0;
			MUX_SEL <= 4'h0;
			TRACK <= 1'b0;
			DMA_ID_REQ <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			RESULT_VALID <= 1'b0;
			if (state_q == ACS_HOLD && adc_tick && bit_q == 4'h0)
			begin
				RESULT <= sar_d;
				RESULT_VALID <= 1'b1;
			end
			MUX_SEL <= (chan_q == ACS_CODE_TEMP) ? ACS_CH_TEMP : chan_q;
			TRACK <= (state_q == ACS_SAMPLE) || (state_q == ACS_SYNC);
			DMA_ID_REQ <= (state_q == ACS_IDLE) && start_req && dma_mode && !dma_wait_q;
			// busy follows the sequencer; drops without software action
			busy_q <= (state_q != ACS_IDLE);
		end
	end

	// ============================================================
	// register read port; status writes are ignored
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			SFR_RDATA <= ACS_STATUS_RESET;
		else if (SFR_RD && SFR_ADDR == ACS_STATUS_ADDR)
			SFR_RDATA <= {busy_q, 7'h00};
		else if (SFR_RD && SFR_ADDR == ACS_CONTROL_TWO_ADDR)
			SFR_RDATA <= control_two_q;
		else if (SFR_RD && SFR_ADDR == ACS_CONTROL_ONE_ADDR)
			SFR_RDATA <= control_one_q;
		else
			SFR_RDATA <= 8'h00;
	end

	// ============================================================
	// checks
	sequence s_sample_then_hold;
		(state_q == ACS_SAMPLE) ##[1:16] (state_q == ACS_HOLD);
	endsequence

	AST_BUSY_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state_q != ACS_IDLE) |=> busy_q)
		else $error("busy low during active cycle");
	AST_BUSY_DROPS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state_q == ACS_IDLE && $past(state_q) == ACS_IDLE) |=> !busy_q)
		else $error("busy stuck after cycle end");
	AST_RESERVED_BITS_ZERO: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		$past(SFR_RD) && $past(SFR_ADDR) == ACS_STATUS_ADDR |-> SFR_RDATA[6:0] == 7'h00)
		else $error("reserved status bits nonzero");
	AST_STATUS_READ: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(SFR_RD && SFR_ADDR == ACS_STATUS_ADDR) |=> SFR_RDATA[ACS_BUSY_BIT] == $past(busy_q))
		else $error("status read wrong busy");
	AST_SAMPLE_HOLD: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		$rose(state_q == ACS_SAMPLE) |-> s_sample_then_hold)
		else $error("sample not followed by hold");
	AST_RESULT_LATCH: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		RESULT_VALID |-> $past(state_q) == ACS_HOLD && $past(bit_q) == 4'h0)
		else $error("result outside search end");
	AST_CHAN_SEL: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state_q == ACS_IDLE && start_req && !dma_mode && code_valid && !CAL_START)
		|=> chan_q == $past(control_two_q[3:0]))
		else $error("wrong channel taken");
	AST_DMA_CHAN: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state_q == ACS_SYNC && $past(state_q) == ACS_IDLE && $past(dma_mode))
		|-> chan_q == $past(DMA_CHANNEL_ID))
		else $error("dma channel not from memory id");
	AST_RESERVED_BITS_CODE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		(state_q == ACS_SYNC) |-> (chan_q <= ACS_CODE_LAST_EXT || chan_q == ACS_CODE_TEMP))
		else $error("reserved code converted");
endmodule

/* tb_adc_channel_select_busy_status.sv */
module tb_adc_channel_select_busy_status
	import acs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// signals
	logic SYS_CLK = 1'b0, ARST_N = 1'b0, SFR_WR = 1'b0, SFR_RD = 1'b0, CAL_START = 1'b0;
	logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA;
	logic DMA_ID_VALID, DMA_ID_REQ, COMP_HI, TRACK, RESULT_VALID, DMA_DONE;
	logic [3:0] DMA_CHANNEL_ID, MUX_SEL;
	logic [11:0] SAR_TRIAL, RESULT;
	logic [7:0] rd_q;
	int bad_count = 0, tests_run = 0, n;
	logic [3:0] dma_ids [0:3] = '{4'h2, 4'h8, 4'h5, 4'h3};
	always #12.5 SYS_CLK = ~SYS_CLK;
	acs_top uut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .SFR_ADDR(SFR_ADDR),
		.SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
		.CAL_START(CAL_START), .DMA_ID_VALID(DMA_ID_VALID), .DMA_CHANNEL_ID(DMA_CHANNEL_ID),
		.DMA_ID_REQ(DMA_ID_REQ), .COMP_HI(COMP_HI), .MUX_SEL(MUX_SEL), .TRACK(TRACK),
		.SAR_TRIAL(SAR_TRIAL), .RESULT(RESULT), .RESULT_VALID(RESULT_VALID), .DMA_DONE(DMA_DONE));
	acs_far_model far (.clk(SYS_CLK), .arst_n(ARST_N), .trial(SAR_TRIAL), .mux_sel(MUX_SEL),
		.id_req(DMA_ID_REQ), .comp_hi(COMP_HI), .id_valid(DMA_ID_VALID),
		.channel_id(DMA_CHANNEL_ID));
	// ============================================================
	// access tasks
	task tick;
		@(posedge SYS_CLK);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		SFR_WR <= 1'b1;
		SFR_ADDR <= a;
		SFR_WDATA <= d;
		@(posedge SYS_CLK);
		SFR_WR <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge SYS_CLK);
		SFR_RD <= 1'b1;
		SFR_ADDR <= a;
		@(posedge SYS_CLK);
		SFR_RD <= 1'b0;
		#1;
		rd_q = SFR_RDATA;
	endtask
	task chk(input logic [11:0] g, input logic [11:0] e);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wait_rv;
		n = 0;
		while (RESULT_VALID !== 1'b1 && n < 400)
		begin
			tick;
			n++;
		end
		chk(12'(n < 400), 12'h001);
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog: whole sequence needs under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge SYS_CLK);
		bad_count++;
		report_and_stop;
	end
	// ============================================================
	// tests
	initial
	begin
		repeat (3) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		rd(ACS_STATUS_ADDR);
		chk({4'h0, rd_q}, {4'h0, ACS_STATUS_RESET});
		rd(8'h00);
		chk({4'h0, rd_q}, 12'h000);
		$display("test reset done");
		for (int c = 0; c <= 8; c++)
		begin
			wr(ACS_CONTROL_ONE_ADDR, 8'(c % 4) << ACS_ACQ_LSB);
			wr(ACS_CONTROL_TWO_ADDR, 8'h10 | 8'(c));
			n = 0;
			while (TRACK !== 1'b1 && n < 20)
			begin
				tick;
				n++;
			end
			chk({8'h0, MUX_SEL}, 12'(c));
			n = 0;
			while (TRACK === 1'b1 && n < 50)
			begin
				tick;
				n++;
			end
			chk(12'(n), 12'(2 + c % 4));
			rd(ACS_STATUS_ADDR);
			chk({4'h0, rd_q}, 12'h080);
			wait_rv;
			chk(RESULT, {4'(c), 8'hA5});
			repeat (3) tick;
			rd(ACS_STATUS_ADDR);
			chk({4'h0, rd_q}, 12'h000);
			repeat (12) tick;
		end
		$display("test channels done");
		wr(ACS_CONTROL_TWO_ADDR, 8'h19);
		repeat (6) tick;
		chk({11'h0, TRACK}, 12'h000);
		rd(ACS_STATUS_ADDR);
		chk({4'h0, rd_q}, 12'h000);
		$display("test reserved done");
		@(posedge SYS_CLK);
		CAL_START <= 1'b1;
		@(posedge SYS_CLK);
		CAL_START <= 1'b0;
		rd(ACS_STATUS_ADDR);
		chk({4'h0, rd_q}, 12'h080);
		n = 0;
		while (rd_q !== 8'h00 && n < 60)
		begin
			rd(ACS_STATUS_ADDR);
			n++;
		end
		chk({4'h0, rd_q}, 12'h000);
		$display("test calibration done");
		wr(ACS_CONTROL_ONE_ADDR, 8'h30);
		wr(ACS_CONTROL_TWO_ADDR, 8'h67);
		for (int i = 0; i < 4; i++)
		begin
			wait_rv;
			chk(RESULT, {dma_ids[i], 8'hA5});
			tick;
		end
		n = 0;
		while (DMA_DONE !== 1'b1 && n < 400)
		begin
			tick;
			n++;
		end
		chk(12'(n < 400), 12'h001);
		repeat (4) tick;
		rd(ACS_STATUS_ADDR);
		chk({4'h0, rd_q}, 12'h000);
		$display("test dma done");
		report_and_stop;
	end
endmodule
